// >>> design/link_enh_pkg.sv
package link_enh_pkg;

  // register byte offsets
  localparam logic [11:0] LINK_ENHANCE_SET_OFS   = 12'ha88;
  localparam logic [11:0] LINK_ENHANCE_CLEAR_OFS = 12'ha8c;
  localparam logic [7:0]  CFG_LINK_ENHANCE_OFS   = 8'hf4;

  // field positions
  localparam int NO_REORDER_SEND_BIT  = 15;
  localparam int SEND_THRESH_LO       = 12;
  localparam int SEND_THRESH_HI       = 13;
  localparam int TRANSPORT_STAMP_BIT  = 10;
  localparam int VIDEO_STAMP_BIT      = 8;

  // implemented bits and reset value of the low half-word
  localparam logic [15:0] IMPL_MASK   = 16'hb500;
  localparam logic [15:0] CTL_RESET   = 16'h1000;

  // threshold codes
  localparam logic [1:0] THRESH_2K    = 2'h0;
  localparam logic [1:0] THRESH_1K7   = 2'h1;
  localparam logic [1:0] THRESH_1K    = 2'h2;
  localparam logic [1:0] THRESH_512   = 2'h3;

  // start levels in bytes
  localparam int LEVEL_1K7 = 1740;
  localparam int LEVEL_1K  = 1024;
  localparam int LEVEL_512 = 512;

  // stream format codes
  localparam logic [5:0] FMT_TRANSPORT = 6'h20;
  localparam logic [5:0] FMT_VIDEO     = 6'h00;

  typedef enum logic [1:0] {
    SEND_IDLE = 2'h0,
    SEND_WAIT = 2'h1,
    SEND_BUSY = 2'h3
  } send_state_e;

  // memory-mapped request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  // configuration-space request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } cfg_req_s;

  // eeprom preload
  typedef struct packed {
    logic        load;
    logic [15:0] mask;
    logic [15:0] data;
  } rom_load_s;

  // asynchronous send queue status
  typedef struct packed {
    logic        pending;
    logic        whole;
    logic        done;
    logic        underrun;
    logic        retrying;
    logic        retries_zero;
    logic [11:0] count;
  } queue_stat_s;

endpackage : link_enh_pkg

// >>> design/send_start_gate.sv
`timescale 1ns/1ps
module send_start_gate #(
  parameter int CW = 12
) (
  // settings
  input  wire logic [1:0]    thresh_i,
  input  wire logic          force_whole_i,
  // queue fill
  input  wire logic [CW-1:0] count_i,
  input  wire logic          whole_i,
  // decision
  output logic               go_o,
  output logic               store_fwd_o
);
  import link_enh_pkg::*;

  logic [CW-1:0] level;

  always_comb begin
    case (thresh_i)
      THRESH_1K7: level = CW'(LEVEL_1K7);
      THRESH_1K:  level = CW'(LEVEL_1K);
      THRESH_512: level = CW'(LEVEL_512);
      default:    level = '0;
    endcase
  end

  // partial start only when nothing forces a whole packet
  assign store_fwd_o = force_whole_i || (thresh_i == THRESH_2K);
  assign go_o        = whole_i || (!store_fwd_o && count_i >= level);
endmodule : send_start_gate

// >>> design/link_enhancement_control.sv
// Function
// - set address sets written ones, clear address clears written ones
// - configuration-space register and memory pair share one storage
// - eeprom may preload selected bits in place of software
// - reserved upper half and reserved single bits read as zero
// - pipelining-disable bit stops out-of-order sending of async packets
// - threshold code picks start level: 2K, 1.7K, 1K or 512 bytes
// - threshold field resets to the 1.7K setting
// - programmed threshold applies only until the first queue underrun while sending
// - a retried packet is sent store-and-forward
// - partial threshold: start at the level or when a whole packet waits
// - after an underrun, next attempt waits for the whole packet
// - 2K setting waits for end-of-packet token before starting
// - zero retries register forces store-and-forward always
// - transport stamp bit enables stamping for format 20h streams
// - video stamp bit enables stamping for format 00h streams
`timescale 1ns/1ps
module link_enhancement_control #(
  parameter int CW = 12
) (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      reset_n_i,
  // memory-mapped access
  input  wire link_enh_pkg::mem_req_s    mem_req_i,
  output logic [31:0]                    mem_rdata_o,
  output logic                           mem_rvalid_o,
  // configuration-space access
  input  wire link_enh_pkg::cfg_req_s    cfg_req_i,
  output logic [31:0]                    cfg_rdata_o,
  output logic                           cfg_rvalid_o,
  // eeprom preload
  input  wire link_enh_pkg::rom_load_s   rom_load_i,
  // asynchronous send queue
  input  wire link_enh_pkg::queue_stat_s queue_i,
  output logic                           send_start_o,
  output logic                           sending_o,
  output logic                           no_reorder_send_o,
  output logic                           underrun_seen_o,
  // isochronous transmit stamping
  input  wire logic [5:0]                stream_format_code_i,
  output logic                           stamp_apply_o
);
  import link_enh_pkg::*;

  typedef struct packed {
    logic [15:0] ctl;
    send_state_e st;
    logic        underrun_seen;
    logic        start;
    logic [31:0] rdata;
    logic        rvalid;
    logic [31:0] cfg_rdata;
    logic        cfg_rvalid;
    logic        no_reorder;
    logic        stamp;
    logic        busy;
  } state_s;

  state_s cur;
  state_s next_cur;

  logic hit_set;
  logic hit_clr;
  logic hit_cfg;
  logic go;
  logic store_fwd;
  logic force_whole;

  assign hit_set = mem_req_i.addr == LINK_ENHANCE_SET_OFS;
  assign hit_clr = mem_req_i.addr == LINK_ENHANCE_CLEAR_OFS;
  assign hit_cfg = cfg_req_i.addr == CFG_LINK_ENHANCE_OFS;

  // underrun, retry and zero retries all fall back to whole packets
  assign force_whole = cur.underrun_seen || queue_i.retrying
                       || queue_i.retries_zero;

  send_start_gate #(
    .CW (CW)
  ) u_gate (
    .thresh_i      (cur.ctl[SEND_THRESH_HI:SEND_THRESH_LO]),
    .force_whole_i (force_whole),
    .count_i       (queue_i.count),
    .whole_i       (queue_i.whole),
    .go_o          (go),
    .store_fwd_o   (store_fwd)
  );

  always_comb begin
    next_cur = cur;
    next_cur.start = 1'b0;
    next_cur.rvalid = 1'b0;
    next_cur.cfg_rvalid = 1'b0;

    // one writer per cycle: eeprom, then config space, then memory pair
    if (rom_load_i.load) begin
      next_cur.ctl = ((cur.ctl & ~rom_load_i.mask)
                     | (rom_load_i.data & rom_load_i.mask)) & IMPL_MASK;
    end else if (cfg_req_i.wr && hit_cfg) begin
      next_cur.ctl = cfg_req_i.wdata[15:0] & IMPL_MASK;
    end else if (mem_req_i.wr && hit_set) begin
      next_cur.ctl = cur.ctl | (mem_req_i.wdata[15:0] & IMPL_MASK);
    end else if (mem_req_i.wr && hit_clr) begin
      next_cur.ctl = cur.ctl & ~(mem_req_i.wdata[15:0] & IMPL_MASK);
    end

    // reads show storage before this cycle's write
    if (mem_req_i.rd) begin
      next_cur.rvalid = 1'b1;
      next_cur.rdata  = (hit_set || hit_clr) ?
                        {16'h0000, cur.ctl & IMPL_MASK} : 32'h0000_0000;
    end
    if (cfg_req_i.rd) begin
      next_cur.cfg_rvalid = 1'b1;
      next_cur.cfg_rdata  = hit_cfg ?
                            {16'h0000, cur.ctl & IMPL_MASK} : 32'h0000_0000;
    end

    next_cur.no_reorder = cur.ctl[NO_REORDER_SEND_BIT];
    next_cur.stamp =
      (cur.ctl[TRANSPORT_STAMP_BIT]
        && stream_format_code_i == FMT_TRANSPORT)
      || (cur.ctl[VIDEO_STAMP_BIT]
        && stream_format_code_i == FMT_VIDEO);

    // sticky so every later attempt waits for a whole packet
    if (queue_i.underrun && cur.st == SEND_BUSY) begin
      next_cur.underrun_seen = 1'b1;
    end

    case (cur.st)
      SEND_IDLE: begin
        if (queue_i.pending) begin
          next_cur.st = SEND_WAIT;
        end
      end
      SEND_WAIT: begin
        if (go) begin
          next_cur.st    = SEND_BUSY;
          next_cur.start = 1'b1;
        end
      end
      SEND_BUSY: begin
        if (queue_i.underrun || queue_i.done) begin
          next_cur.st = SEND_IDLE;
        end
      end
      default: begin
        next_cur.st = SEND_IDLE;
      end
    endcase

    // registered copy so the busy output needs no decode after the flop
    next_cur.busy = (next_cur.st == SEND_BUSY);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur            <= '0;
      cur.ctl        <= CTL_RESET;
      cur.st         <= SEND_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  assign mem_rdata_o       = cur.rdata;
  assign mem_rvalid_o      = cur.rvalid;
  assign cfg_rdata_o       = cur.cfg_rdata;
  assign cfg_rvalid_o      = cur.cfg_rvalid;
  assign send_start_o      = cur.start;
  assign sending_o         = cur.busy;
  assign no_reorder_send_o = cur.no_reorder;
  assign underrun_seen_o   = cur.underrun_seen;
  assign stamp_apply_o     = cur.stamp;

  // software setup before link power-on is the driver's duty

  logic only_set;
  logic only_clr;
  assign only_set = mem_req_i.wr && hit_set && !rom_load_i.load
                    && !(cfg_req_i.wr && hit_cfg);
  assign only_clr = mem_req_i.wr && hit_clr && !rom_load_i.load
                    && !(cfg_req_i.wr && hit_cfg);

  set_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    only_set |=> (cur.ctl & $past(mem_req_i.wdata[15:0]) & IMPL_MASK)
                 == ($past(mem_req_i.wdata[15:0]) & IMPL_MASK))
    else $error("set write did not set bits");

  clear_keep_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    only_clr |=> ((cur.ctl & $past(mem_req_i.wdata[15:0])) == 16'h0000)
                 && ((cur.ctl & ~$past(mem_req_i.wdata[15:0]))
                     == ($past(cur.ctl) & ~$past(mem_req_i.wdata[15:0]))))
    else $error("clear write wrong");

  alias_view_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (mem_req_i.rd && cfg_req_i.rd && hit_set && hit_cfg)
      |=> cur.rdata == cur.cfg_rdata)
    else $error("config and memory views differ");

  rsvd_zero_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cur.rvalid |-> (cur.rdata[31:16] == 16'h0000)
                   && ((cur.rdata[15:0] & ~IMPL_MASK) == 16'h0000))
    else $error("reserved bits read nonzero");

  rom_load_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    rom_load_i.load |=> (cur.ctl & $past(rom_load_i.mask))
                        == ($past(rom_load_i.data & rom_load_i.mask)
                            & IMPL_MASK))
    else $error("eeprom preload not applied");

  reorder_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ##1 no_reorder_send_o == $past(cur.ctl[NO_REORDER_SEND_BIT]))
    else $error("pipelining disable not followed");

  whole_wait_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (cur.st == SEND_WAIT && store_fwd && !queue_i.whole) |=> !send_start_o)
    else $error("store-and-forward started early");

  level_go_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (cur.st == SEND_WAIT && !force_whole
     && cur.ctl[SEND_THRESH_HI:SEND_THRESH_LO] == THRESH_512
     && queue_i.count >= CW'(LEVEL_512)) |=> send_start_o ##1 sending_o)
    else $error("threshold start missed");

  underrun_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (cur.st == SEND_BUSY && queue_i.underrun)
      |=> underrun_seen_o && !sending_o)
    else $error("underrun not recorded");

  retry_sf_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    queue_i.retrying |-> store_fwd)
    else $error("retry not store-and-forward");

  stamp_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (cur.ctl[VIDEO_STAMP_BIT] && stream_format_code_i == FMT_VIDEO)
      |=> stamp_apply_o)
    else $error("video stamp not applied");

  stamp_off_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (!cur.ctl[TRANSPORT_STAMP_BIT] && !cur.ctl[VIDEO_STAMP_BIT])
      |=> !stamp_apply_o)
    else $error("stamp applied while disabled");

  stamp_ts_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (cur.ctl[TRANSPORT_STAMP_BIT] && stream_format_code_i == FMT_TRANSPORT)
      |=> stamp_apply_o)
    else $error("transport stamp not applied");

  cfg_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (cfg_req_i.wr && hit_cfg && !rom_load_i.load)
      |=> cur.ctl == ($past(cfg_req_i.wdata[15:0]) & IMPL_MASK))
    else $error("config write not stored");

  stray_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (mem_req_i.wr && !hit_set && !hit_clr && !rom_load_i.load
     && !(cfg_req_i.wr && hit_cfg)) |=> $stable(cur.ctl))
    else $error("unmapped write changed storage");

  start_wait_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (cur.st != SEND_WAIT) |=> !send_start_o)
    else $error("start outside wait state");

  start_busy_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    send_start_o |-> sending_o)
    else $error("start without sending");

  underrun_hold_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    underrun_seen_o |=> underrun_seen_o)
    else $error("underrun record lost");

  cfg_rsvd_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cur.cfg_rvalid |-> (cur.cfg_rdata[31:16] == 16'h0000)
                       && ((cur.cfg_rdata[15:0] & ~IMPL_MASK) == 16'h0000))
    else $error("reserved config bits read nonzero");

  read_answer_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    mem_req_i.rd |=> mem_rvalid_o)
    else $error("read not answered");

endmodule : link_enhancement_control

// >>> bench/link_host_model.sv
`timescale 1ns/1ps
module link_host_model (
  // clock
  input  wire logic              clk_i,
  // requests
  output link_enh_pkg::mem_req_s mem_req_o,
  output link_enh_pkg::cfg_req_s cfg_req_o,
  // answers
  input  wire logic [31:0]       mem_rdata_i,
  input  wire logic              mem_rvalid_i,
  input  wire logic [31:0]       cfg_rdata_i,
  input  wire logic              cfg_rvalid_i
);
  import link_enh_pkg::*;

  initial begin
    mem_req_o = '0;
    cfg_req_o = '0;
  end

  // one strobe per call, held for a single clock cycle
  task automatic access(input logic cfg, input logic wr,
                        input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic ok);
    @(posedge clk_i);
    if (cfg) begin
      cfg_req_o <= '{~wr, wr, addr[7:0], wdata};
    end else begin
      mem_req_o <= '{~wr, wr, addr, wdata};
    end
    @(posedge clk_i);
    mem_req_o <= '0;
    cfg_req_o <= '0;
    #1;
    ok = cfg ? cfg_rvalid_i : mem_rvalid_i;
    rdata = cfg ? cfg_rdata_i : mem_rdata_i;
  endtask : access

  // both views read in the same cycle
  task automatic dual_rd(input logic [11:0] addr,
                         output logic [31:0] mdata,
                         output logic [31:0] cdata);
    @(posedge clk_i);
    mem_req_o <= '{1'b1, 1'b0, addr, 32'h0000_0000};
    cfg_req_o <= '{1'b1, 1'b0, CFG_LINK_ENHANCE_OFS, 32'h0000_0000};
    @(posedge clk_i);
    mem_req_o <= '0;
    cfg_req_o <= '0;
    #1;
    mdata = mem_rdata_i;
    cdata = cfg_rdata_i;
  endtask : dual_rd
endmodule : link_host_model

// >>> bench/link_enhancement_control_tb.sv
`timescale 1ns/1ps
module link_enhancement_control_tb;
  import link_enh_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  mem_req_s    mem_req;
  cfg_req_s    cfg_req;
  rom_load_s   rom_load = '0;
  queue_stat_s q = '0;
  logic [5:0]  fmt = 6'h3f;
  logic [31:0] mem_rdata, cfg_rdata;
  logic        mem_rvalid, cfg_rvalid, send_start, sending;
  logic        no_reorder, underrun_seen, stamp;
  logic [31:0] dual_m, dual_c;
  int          failures = 0;
  int          cmp_count = 0;
  logic [5:0]  fmts [3] = '{6'h00, 6'h20, 6'h01};
  // code 00 never reaches a level, so the top count stands in for it
  int          lvl [4] = '{4095, LEVEL_1K7, LEVEL_1K, LEVEL_512};

  always #12.5 clk_i = ~clk_i;

  link_host_model i_link_host_model (.clk_i(clk_i), .mem_req_o(mem_req),
    .cfg_req_o(cfg_req), .mem_rdata_i(mem_rdata), .mem_rvalid_i(mem_rvalid),
    .cfg_rdata_i(cfg_rdata), .cfg_rvalid_i(cfg_rvalid));

  link_enhancement_control i_link_enhancement_control (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .mem_req_i(mem_req), .mem_rdata_o(mem_rdata),
    .mem_rvalid_o(mem_rvalid), .cfg_req_i(cfg_req), .cfg_rdata_o(cfg_rdata),
    .cfg_rvalid_o(cfg_rvalid), .rom_load_i(rom_load), .queue_i(q),
    .send_start_o(send_start), .sending_o(sending),
    .no_reorder_send_o(no_reorder), .underrun_seen_o(underrun_seen),
    .stream_format_code_i(fmt), .stamp_apply_o(stamp));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic cfg, input logic [11:0] a,
                    input logic [31:0] d);
    logic [31:0] r;
    logic        ok;
    i_link_host_model.access(cfg, 1'b1, a, d, r, ok);
  endtask : wr

  task automatic rd_chk(input logic cfg, input logic [11:0] a,
                        input logic [31:0] exp);
    logic [31:0] r;
    logic        ok;
    i_link_host_model.access(cfg, 1'b0, a, 32'h0, r, ok);
    check(32'(ok), 32'h1);
    check(r, exp);
  endtask : rd_chk

  // a refused start is released by the whole packet so the queue drains
  task automatic send(input logic [11:0] cnt, input logic whole,
                      input logic [1:0] fl, input logic exp, input logic ur);
    logic seen;
    seen = 1'b0;
    @(posedge clk_i);
    q <= '{1'b1, whole, 1'b0, 1'b0, fl[1], fl[0], cnt};
    repeat (4) begin
      @(posedge clk_i);
      #1;
      seen = seen | send_start;
    end
    check(32'(seen), 32'(exp));
    @(posedge clk_i);
    q.whole <= 1'b1;
    q.pending <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check(32'(sending), 32'h1);
    @(posedge clk_i);
    if (ur) begin
      q.underrun <= 1'b1;
    end else begin
      q.done <= 1'b1;
    end
    @(posedge clk_i);
    q <= '0;
    #1;
    check(32'(sending), 32'h0);
  endtask : send

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #50000;
    failures++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk(1'b0, LINK_ENHANCE_SET_OFS, 32'h1000);
    rd_chk(1'b0, LINK_ENHANCE_CLEAR_OFS, 32'h1000);
    wr(1'b0, LINK_ENHANCE_SET_OFS, 32'hffffffff);
    rd_chk(1'b1, 12'(CFG_LINK_ENHANCE_OFS), 32'hb500);
    wr(1'b0, LINK_ENHANCE_CLEAR_OFS, 32'h8000);
    rd_chk(1'b0, LINK_ENHANCE_SET_OFS, 32'h3500);
    check(32'(no_reorder), 32'h0);
    wr(1'b1, 12'(CFG_LINK_ENHANCE_OFS), 32'h8000);
    rd_chk(1'b0, LINK_ENHANCE_CLEAR_OFS, 32'h8000);
    i_link_host_model.dual_rd(LINK_ENHANCE_SET_OFS, dual_m, dual_c);
    check(dual_m, 32'h8000);
    check(dual_c, 32'h8000);
    check(32'(no_reorder), 32'h1);
    rd_chk(1'b0, 12'h123, 32'h0);
    wr(1'b0, 12'h123, 32'hffffffff);
    rd_chk(1'b0, LINK_ENHANCE_SET_OFS, 32'h8000);
    @(posedge clk_i);
    rom_load <= '{1'b1, 16'h0500, 16'h0100};
    @(posedge clk_i);
    rom_load <= '0;
    rd_chk(1'b0, LINK_ENHANCE_SET_OFS, 32'h8100);
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, LINK_ENHANCE_CLEAR_OFS, 32'h0500);
      wr(1'b0, LINK_ENHANCE_SET_OFS, {21'h0, i[1], 1'b0, i[0], 8'h0});
      foreach (fmts[j]) begin
        @(posedge clk_i);
        fmt <= fmts[j];
        repeat (2) @(posedge clk_i);
        #1;
        check(32'(stamp), 32'((fmts[j] == 6'h20 && i[1])
                            || (fmts[j] == 6'h00 && i[0])));
      end
    end
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, LINK_ENHANCE_CLEAR_OFS, 32'h3000);
      wr(1'b0, LINK_ENHANCE_SET_OFS, {18'h0, i[1:0], 12'h0});
      send(12'(lvl[i] - 1), 1'b0, 2'b00, 1'b0, 1'b0);
      send(12'(lvl[i]), 1'b0, 2'b00, i != 0, 1'b0);
    end
    send(12'hfff, 1'b0, 2'b01, 1'b0, 1'b0);
    send(12'hfff, 1'b0, 2'b10, 1'b0, 1'b0);
    @(posedge clk_i);
    q.underrun <= 1'b1;
    @(posedge clk_i);
    q.underrun <= 1'b0;
    #1;
    check(32'(underrun_seen), 32'h0);
    send(12'h0, 1'b1, 2'b00, 1'b1, 1'b1);
    check(32'(underrun_seen), 32'h1);
    send(12'hfff, 1'b0, 2'b00, 1'b0, 1'b0);
    send(12'h0, 1'b1, 2'b00, 1'b1, 1'b0);
    end_of_test();
  end
endmodule : link_enhancement_control_tb
